// [irq_gate_params.svh]
// Constants for the extended interrupt enable gating block.
// Assumes inclusion by the design modules, the checker and the bench only.
`ifndef IRQ_GATE_PARAMS_SVH
`define IRQ_GATE_PARAMS_SVH

// Printed offsets are not word multiples: they are register indices
`define EXT_IRQ_EN_IDX 8'h9B
`define EXT_IRQ_EN2_IDX 8'h9C
`define EXT_IRQ_EN_ADDR 12'h26C
`define EXT_IRQ_EN2_ADDR 12'h270
`define GATED_STATUS_ADDR 12'h274
`define SOURCE_STATUS_ADDR 12'h278

`define EXT_IRQ_EN_RESET 8'h00
`define EXT_IRQ_EN2_RESET 8'h00
`define EXT_IRQ_EN2_MASK 8'h07

`define BIT_TIMER2 7
`define BIT_SPI 6
`define BIT_FAULT_BRAKE 5
`define BIT_WATCHDOG 4
`define BIT_PWM 3
`define BIT_CAPTURE 2
`define BIT_PIN 1
`define BIT_I2C 0
`define BIT_WAKEUP 2
`define BIT_TIMER3 1
`define BIT_SERIAL1 0

`define NUM_SOURCES 11

`endif

// [irq_gate_pkg.sv]
// Types shared by the extended interrupt enable gating block.
// Assumes nothing beyond the constants header.
package irq_gate_pkg;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_e;
  typedef logic [7:0] byte_t;
endpackage

// [irq_source_gate.sv]
// Gates a vector of source conditions with a vector of enable bits.
// Assumes the sources are synchronous to clk_i; output is registered.
`include "irq_gate_params.svh"
module irq_source_gate #(
  parameter int N = `NUM_SOURCES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [N-1:0] enable_i,
  input wire logic [N-1:0] source_i,
  output logic [N-1:0] request_o
);
  logic [N-1:0] request_nxt;

  assign request_nxt = enable_i & source_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      request_o <= '0;
    end else begin
      request_o <= request_nxt;
    end
  end
endmodule // irq_source_gate

// [ext_irq_enable.sv]
// Extended interrupt enable registers and request gating, APB slave.
// Assumes peripheral flags are synchronous levels that the peripherals
// own and clear; requests feed the core's priority and vector logic.
`include "irq_gate_params.svh"
module ext_irq_enable
  import irq_gate_pkg::*;
#(
  parameter int PIN_FLAGS = 8,
  parameter int CAP_FLAGS = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic timer2_overflow_flag_i,
  input wire logic spi_transfer_done_flag_i,
  input wire logic spi_overrun_flag_i,
  input wire logic spi_mode_fault_flag_i,
  input wire logic fault_brake_flag_i,
  input wire logic watchdog_timeout_flag_i,
  input wire logic pwm_period_flag_i,
  input wire logic [CAP_FLAGS-1:0] capture_channel_flags_i,
  input wire logic [PIN_FLAGS-1:0] pin_irq_flags_i,
  input wire logic i2c_state_flag_i,
  input wire logic i2c_timeout_flag_i,
  input wire logic wakeup_timeout_flag_i,
  input wire logic timer3_overflow_flag_i,
  input wire logic serial1_tx_done_flag_i,
  input wire logic serial1_rx_done_flag_i,
  output logic timer2_irq_o,
  output logic spi_irq_o,
  output logic fault_brake_irq_o,
  output logic watchdog_irq_o,
  output logic pwm_irq_o,
  output logic capture_irq_o,
  output logic pin_irq_o,
  output logic i2c_irq_o,
  output logic wakeup_timer_irq_o,
  output logic timer3_irq_o,
  output logic serial1_irq_o
);
  byte_t ext_irq_enable_r;
  byte_t ext_irq_enable_second_r;
  apb_state_e state_r;
  apb_state_e state_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;

  wire logic timer2_irq_enable = ext_irq_enable_r[`BIT_TIMER2];
  wire logic spi_irq_enable = ext_irq_enable_r[`BIT_SPI];
  wire logic fault_brake_irq_enable = ext_irq_enable_r[`BIT_FAULT_BRAKE];
  wire logic watchdog_irq_enable = ext_irq_enable_r[`BIT_WATCHDOG];
  wire logic pwm_irq_enable = ext_irq_enable_r[`BIT_PWM];
  wire logic capture_irq_enable = ext_irq_enable_r[`BIT_CAPTURE];
  wire logic pin_irq_enable = ext_irq_enable_r[`BIT_PIN];
  wire logic i2c_irq_enable = ext_irq_enable_r[`BIT_I2C];
  wire logic wakeup_timer_irq_enable =
    ext_irq_enable_second_r[`BIT_WAKEUP];
  wire logic timer3_irq_enable = ext_irq_enable_second_r[`BIT_TIMER3];
  wire logic serial1_irq_enable = ext_irq_enable_second_r[`BIT_SERIAL1];

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // Source conditions
  wire logic src_timer2 = timer2_overflow_flag_i;
  wire logic src_spi = spi_transfer_done_flag_i | spi_overrun_flag_i |
    spi_mode_fault_flag_i;
  wire logic src_fault_brake = fault_brake_flag_i;
  wire logic src_watchdog = watchdog_timeout_flag_i;
  wire logic src_pwm = pwm_period_flag_i;
  wire logic src_capture = |capture_channel_flags_i;
  wire logic src_pin = |pin_irq_flags_i;
  wire logic src_i2c = i2c_state_flag_i | i2c_timeout_flag_i;
  wire logic src_wakeup = wakeup_timeout_flag_i;
  wire logic src_timer3 = timer3_overflow_flag_i;
  wire logic src_serial1 = serial1_tx_done_flag_i | serial1_rx_done_flag_i;

  wire logic [`NUM_SOURCES-1:0] enable_vec = {
    timer2_irq_enable, spi_irq_enable, fault_brake_irq_enable,
    watchdog_irq_enable, pwm_irq_enable, capture_irq_enable,
    pin_irq_enable, i2c_irq_enable, wakeup_timer_irq_enable,
    timer3_irq_enable, serial1_irq_enable};
  wire logic [`NUM_SOURCES-1:0] source_vec = {
    src_timer2, src_spi, src_fault_brake, src_watchdog, src_pwm,
    src_capture, src_pin, src_i2c, src_wakeup, src_timer3, src_serial1};
  logic [`NUM_SOURCES-1:0] request_vec;

  irq_source_gate #(
    .N(`NUM_SOURCES)
  ) u_gate (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .enable_i(enable_vec),
    .source_i(source_vec),
    .request_o(request_vec)
  );

  assign timer2_irq_o = request_vec[10];
  assign spi_irq_o = request_vec[9];
  assign fault_brake_irq_o = request_vec[8];
  assign watchdog_irq_o = request_vec[7];
  assign pwm_irq_o = request_vec[6];
  assign capture_irq_o = request_vec[5];
  assign pin_irq_o = request_vec[4];
  assign i2c_irq_o = request_vec[3];
  assign wakeup_timer_irq_o = request_vec[2];
  assign timer3_irq_o = request_vec[1];
  assign serial1_irq_o = request_vec[0];

  // APB decode; answer comes one cycle into the access phase
  wire logic setup_phase = psel_i & ~penable_i;
  wire logic access_take = (state_r == APB_ACCESS) & psel_i & penable_i;
  wire logic hit_en = addr_hit(paddr_i, `EXT_IRQ_EN_ADDR);
  wire logic hit_en2 = addr_hit(paddr_i, `EXT_IRQ_EN2_ADDR);
  wire logic hit_gated = addr_hit(paddr_i, `GATED_STATUS_ADDR);
  wire logic hit_source = addr_hit(paddr_i, `SOURCE_STATUS_ADDR);
  wire logic hit_any = hit_en | hit_en2 | hit_gated | hit_source;
  // Write lands at the edge where the master sees pready high
  wire logic do_write = access_take & pwrite_i & pready_o;
  wire logic do_read = access_take & ~pwrite_i & ~pready_o;

  // Status words show the block's own state to software
  wire logic [31:0] gated_word = {21'h0, request_vec};
  wire logic [31:0] source_word = {21'h0, source_vec};
  wire logic [31:0] read_mux =
    hit_en ? {24'h0, ext_irq_enable_r} :
    hit_en2 ? {24'h0, ext_irq_enable_second_r & `EXT_IRQ_EN2_MASK} :
    hit_gated ? gated_word :
    hit_source ? source_word : 32'h0;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      APB_IDLE: begin
        if (setup_phase) begin
          state_nxt = APB_ACCESS;
        end
      end
      APB_ACCESS: begin
        if (pready_o) begin
          state_nxt = setup_phase ? APB_ACCESS : APB_IDLE;
        end
      end
      default: state_nxt = APB_IDLE;
    endcase
  end

  assign pready_nxt = access_take & ~pready_o;
  assign pslverr_nxt = access_take & ~pready_o & ~hit_any;
  assign prdata_nxt = do_read ? read_mux : 32'h0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= APB_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      state_r <= state_nxt;
      pready_o <= pready_nxt;
      pslverr_o <= pslverr_nxt;
      prdata_o <= prdata_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_irq_enable_r <= `EXT_IRQ_EN_RESET;
      ext_irq_enable_second_r <= `EXT_IRQ_EN2_RESET;
    end else begin
      if (do_write && hit_en) begin
        ext_irq_enable_r <= pwdata_i[7:0];
      end
      if (do_write && hit_en2) begin
        ext_irq_enable_second_r <= pwdata_i[7:0] & `EXT_IRQ_EN2_MASK;
      end
    end
  end
endmodule // ext_irq_enable

// [ext_irq_enable_assertions.sv]
// Checker for the extended interrupt enable block, on its ports only.
// Assumes the APB master holds address and direction until pready.
`include "irq_gate_params.svh"
module ext_irq_enable_checker (
  input wire logic clk_i, nrst_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o, pslverr_o,
  input wire logic timer2_overflow_flag_i, spi_transfer_done_flag_i,
  input wire logic spi_overrun_flag_i, spi_mode_fault_flag_i,
  input wire logic [2:0] capture_channel_flags_i,
  input wire logic [7:0] pin_irq_flags_i,
  input wire logic serial1_tx_done_flag_i, serial1_rx_done_flag_i,
  input wire logic timer2_irq_o, spi_irq_o, capture_irq_o, pin_irq_o,
  input wire logic serial1_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i; endsequence
  // Requests only follow a source seen one cycle earlier
  a_timer2_gated: assert property (timer2_irq_o |-> $past(timer2_overflow_flag_i)) else $error("timer2 request without flag");
  a_spi_or_gated: assert property (spi_irq_o |-> $past(spi_transfer_done_flag_i | spi_overrun_flag_i | spi_mode_fault_flag_i)) else $error("spi request without flag");
  a_capture_gated: assert property (capture_irq_o |-> $past(|capture_channel_flags_i)) else $error("capture request without flag");
  a_pin_gated: assert property (pin_irq_o |-> $past(|pin_irq_flags_i)) else $error("pin request without flag");
  a_serial1_gated: assert property (serial1_irq_o |-> $past(serial1_tx_done_flag_i | serial1_rx_done_flag_i)) else $error("serial1 request without flag");
  a_upper_bits_zero: assert property (pready_o && !pwrite_i && paddr_i == `EXT_IRQ_EN2_ADDR |-> prdata_o[31:3] == 29'h0) else $error("upper enable bits not zero");
  a_ready_answer: assert property (setup_s ##1 access_s |-> ##[0:2] pready_o) else $error("no ready after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  a_error_with_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_data_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");
endmodule // ext_irq_enable_checker
bind ext_irq_enable ext_irq_enable_checker u_chk (.clk_i, .nrst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
  .timer2_overflow_flag_i, .spi_transfer_done_flag_i, .spi_overrun_flag_i,
  .spi_mode_fault_flag_i, .capture_channel_flags_i, .pin_irq_flags_i,
  .serial1_tx_done_flag_i, .serial1_rx_done_flag_i, .timer2_irq_o,
  .spi_irq_o, .capture_irq_o, .pin_irq_o, .serial1_irq_o);

// [core_irq_model.sv]
// Stand-in for the core's priority logic: latches the request lines.
// Assumes requests are levels on clk_i; no vectoring is modelled.
module core_irq_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [10:0] req_i,
  output logic [10:0] pending_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) pending_o <= 11'h000;
    else pending_o <= req_i;
  end
endmodule // core_irq_model

// [test_ext_irq_enable.sv]
// Self-checking bench for the extended interrupt enable block.
// Polls pready, so any APB wait count is taken; the design answers with one wait state.
`include "irq_gate_params.svh"
module test_ext_irq_enable;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, er;
  logic [24:0] f = 25'h0;
  logic [10:0] outs, pend;
  int fail_count = 0, compares = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  ext_irq_enable dut (.clk_i, .nrst_i, .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o,
    .pready_o, .pslverr_o, .timer2_overflow_flag_i(f[0]),
    .spi_transfer_done_flag_i(f[1]), .spi_overrun_flag_i(f[2]),
    .spi_mode_fault_flag_i(f[3]), .fault_brake_flag_i(f[4]),
    .watchdog_timeout_flag_i(f[5]), .pwm_period_flag_i(f[6]),
    .capture_channel_flags_i(f[9:7]), .pin_irq_flags_i(f[17:10]),
    .i2c_state_flag_i(f[18]), .i2c_timeout_flag_i(f[19]),
    .wakeup_timeout_flag_i(f[20]), .timer3_overflow_flag_i(f[21]),
    .serial1_tx_done_flag_i(f[22]), .serial1_rx_done_flag_i(f[23]),
    .timer2_irq_o(outs[10]), .spi_irq_o(outs[9]), .fault_brake_irq_o(outs[8]),
    .watchdog_irq_o(outs[7]), .pwm_irq_o(outs[6]), .capture_irq_o(outs[5]),
    .pin_irq_o(outs[4]), .i2c_irq_o(outs[3]), .wakeup_timer_irq_o(outs[2]),
    .timer3_irq_o(outs[1]), .serial1_irq_o(outs[0]));
  core_irq_model core (.clk_i, .nrst_i, .req_i(outs), .pending_o(pend));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1 && cyc < 5000);
    rd = prdata_o; er = pslverr_o;
    psel <= 0; penable <= 0;
  endtask
  task automatic reset_values();
    apb(0, `EXT_IRQ_EN_ADDR, 0); check(rd, 32'h0);
    apb(0, `EXT_IRQ_EN2_ADDR, 0); check(rd, 32'h0);
  endtask
  // Walk one enable at a time with all sources raised, pin through six sub-flags, the others through one
  task automatic gate_walk();
    f <= 25'h7ADE75;
    for (int i = 0; i < 11; i++) begin
      apb(1, `EXT_IRQ_EN_ADDR, i >= 3 ? 32'hFFFFFF00 | (1 << (i - 3)) : 0);
      apb(1, `EXT_IRQ_EN2_ADDR, i < 3 ? 32'h1 << i : 0);
      repeat (3) @(posedge clk_i);
      check(pend, 11'h1 << i);
    end
    apb(0, `SOURCE_STATUS_ADDR, 0); check(rd, 32'h7FF);
    apb(1, `EXT_IRQ_EN_ADDR, 32'hFF); f <= 25'h0;
    repeat (3) @(posedge clk_i);
    check(pend, 11'h000);
  endtask
  task automatic upper_and_unmapped();
    apb(1, `EXT_IRQ_EN2_ADDR, 32'hFF); check(rd, 32'h0);
    apb(0, `EXT_IRQ_EN2_ADDR, 0); check(rd, 32'h07);
    apb(0, 12'h300, 0); check(er, 32'h1);
    check(rd, 32'h0);
  endtask
  task automatic complete_run();
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1;
    reset_values();
    gate_walk();
    upper_and_unmapped();
    complete_run();
  end
endmodule // test_ext_irq_enable
